// ### rtl/vasp_pkg.sv
package vasp_pkg;

    // Target address: six fixed upper bits, lowest from the strap
    localparam logic [5:0] ADDR_HI = 6'h26;
    localparam int ADDR_BITS = 7;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;

    // Clock and link timing
    localparam int CLK_MHZ = 250;
    localparam int DEGLITCH_CYCLES = 3;
    localparam int SCL_PERIOD_NS = 96;
    localparam int QTR_CYCLES = (SCL_PERIOD_NS * CLK_MHZ) / (1000 * 4);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);

    // Byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BITS_PER_SLOT = 4'h9;

    // Reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Host command codes
    typedef enum logic [2:0] {
        CMD_START = 3'b000,
        CMD_STOP = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_READ_ACK = 3'b011,
        CMD_READ_NACK = 3'b100
    } vasp_cmd_t;

endpackage

// ### rtl/vasp_if.sv
`timescale 1ns/1ps
interface vasp_if;
    logic scl_out_host;
    logic scl_oe_host;
    logic sda_out_host;
    logic sda_oe_host;
    logic sda_out_dev;
    logic sda_oe_dev;
    logic scl;
    logic sda;

    // Wired-AND of open-drain drivers with a pull-up
    assign scl = !(scl_oe_host && !scl_out_host);
    assign sda = !(sda_oe_host && !sda_out_host) && !(sda_oe_dev && !sda_out_dev);

    modport dev (
        input scl,
        input sda,
        output sda_out_dev,
        output sda_oe_dev
    );

    modport host (
        input sda,
        output scl_out_host,
        output scl_oe_host,
        output sda_out_host,
        output sda_oe_host
    );
endinterface

// ### rtl/vasp_dev.sv
`timescale 1ns/1ps
module vasp_dev (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic STRAP_I,
    vasp_if.dev bus,
    output logic [7:0] REG_ADDR_O,
    output logic [7:0] REG_WDATA_O,
    output logic REG_WR_O,
    output logic REG_RD_O,
    input wire logic [7:0] REG_RDATA_I
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_INDEX = 4'b0011,
        ST_INDEX_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } vasp_dev_state_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic strap_m;
        logic strap_s;
        logic [2:0] scl_h;
        logic [2:0] sda_h;
        logic scl_f;
        logic sda_f;
        logic scl_fq;
        logic sda_fq;
        vasp_dev_state_t state;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic host_ack;
        logic sda_oe;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vasp_dev_regs_t;

    vasp_dev_regs_t s;
    vasp_dev_regs_t next_s;

    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic match;

    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.rd = 1'b0;
        // Two-stage synchronisers on pins
        next_s.scl_m = bus.scl;
        next_s.scl_s = s.scl_m;
        next_s.sda_m = bus.sda;
        next_s.sda_s = s.sda_m;
        next_s.strap_m = STRAP_I;
        next_s.strap_s = s.strap_m;
        // Level only accepted after three agreeing samples
        next_s.scl_h = {s.scl_h[1:0], s.scl_s};
        next_s.sda_h = {s.sda_h[1:0], s.sda_s};
        if (s.scl_h == {3{s.scl_h[0]}}) begin
            next_s.scl_f = s.scl_h[0];
        end
        if (s.sda_h == {3{s.sda_h[0]}}) begin
            next_s.sda_f = s.sda_h[0];
        end
        next_s.scl_fq = s.scl_f;
        next_s.sda_fq = s.sda_f;

        rise = s.scl_f && !s.scl_fq;
        fall = !s.scl_f && s.scl_fq;
        start = s.scl_f && s.scl_fq && s.sda_fq && !s.sda_f;
        stop = s.scl_f && s.scl_fq && !s.sda_fq && s.sda_f;
        match = s.shift[7:1] == {vasp_pkg::ADDR_HI, s.strap_s};

        // Pointer advances once per transferred data byte
        if (s.wr || s.rd) begin
            next_s.ptr = s.ptr + 8'h01;
        end

        if (start) begin
            next_s.state = ST_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop) begin
            next_s.state = ST_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.state)
                ST_IDLE: begin
                    next_s.sda_oe = 1'b0;
                end
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (rise) begin
                        next_s.shift = {s.shift[6:0], s.sda_f};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (fall && s.bitcnt == vasp_pkg::BITS_PER_BYTE) begin
                        next_s.bitcnt = 4'h0;
                        next_s.sda_oe = 1'b1;
                        if (s.state == ST_ADDR) begin
                            if (match) begin
                                next_s.state = ST_ADDR_ACK;
                            end else begin
                                next_s.state = ST_IDLE;
                                next_s.sda_oe = 1'b0;
                            end
                        end else if (s.state == ST_INDEX) begin
                            next_s.ptr = s.shift;
                            next_s.state = ST_INDEX_ACK;
                        end else begin
                            next_s.wdata = s.shift;
                            next_s.wr = 1'b1;
                            next_s.state = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK: begin
                    if (fall) begin
                        next_s.bitcnt = 4'h0;
                        if (s.state == ST_ADDR_ACK && s.shift[0] == vasp_pkg::DIR_READ) begin
                            next_s.shift = REG_RDATA_I;
                            next_s.rd = 1'b1;
                            next_s.sda_oe = !REG_RDATA_I[7];
                            next_s.state = ST_RDATA;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.state = s.state == ST_ADDR_ACK ? ST_INDEX : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (rise) begin
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (fall) begin
                        if (s.bitcnt == vasp_pkg::BITS_PER_BYTE) begin
                            next_s.sda_oe = 1'b0;
                            next_s.state = ST_RDATA_ACK;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = !s.shift[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (rise) begin
                        next_s.host_ack = !s.sda_f;
                    end else if (fall) begin
                        next_s.bitcnt = 4'h0;
                        if (s.host_ack) begin
                            next_s.shift = REG_RDATA_I;
                            next_s.rd = 1'b1;
                            next_s.sda_oe = !REG_RDATA_I[7];
                            next_s.state = ST_RDATA;
                        end else begin
                            next_s.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_s.state = ST_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Crystal-clock logic has no standby gating
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s <= '{
                scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                strap_m: 1'b0, strap_s: 1'b0,
                scl_h: 3'h7, sda_h: 3'h7,
                scl_f: 1'b1, sda_f: 1'b1, scl_fq: 1'b1, sda_fq: 1'b1,
                state: ST_IDLE, bitcnt: 4'h0, shift: vasp_pkg::BYTE_RST,
                host_ack: 1'b0, sda_oe: 1'b0, ptr: vasp_pkg::PTR_RST,
                wdata: vasp_pkg::BYTE_RST, wr: 1'b0, rd: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    assign bus.sda_out_dev = 1'b0;
    assign bus.sda_oe_dev = s.sda_oe;
    assign REG_ADDR_O = s.ptr;
    assign REG_WDATA_O = s.wdata;
    assign REG_WR_O = s.wr;
    assign REG_RD_O = s.rd;

endmodule

// ### rtl/vasp_host.sv
`timescale 1ns/1ps
module vasp_host (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    vasp_if.host bus,
    input wire logic CMD_VALID_I,
    input wire logic [2:0] CMD_I,
    input wire logic [7:0] CMD_DATA_I,
    output logic CMD_READY_O,
    output logic DONE_O,
    output logic [7:0] RDATA_O,
    output logic ACK_O
);

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_START = 2'b01,
        HS_STOP = 2'b10,
        HS_BIT = 2'b11
    } vasp_host_state_t;

    typedef struct packed {
        logic sda_m;
        logic sda_s;
        vasp_host_state_t state;
        logic [7:0] tick;
        logic [1:0] qtr;
        logic [3:0] bitcnt;
        logic [8:0] tx;
        logic [8:0] rx;
        logic scl_oe;
        logic sda_oe;
        logic ready;
        logic done;
        logic [7:0] rdata;
        logic ack;
    } vasp_host_regs_t;

    vasp_host_regs_t s;
    vasp_host_regs_t next_s;
    logic step;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.sda_m = bus.sda;
        next_s.sda_s = s.sda_m;
        step = s.tick == 8'h00;
        next_s.tick = step ? vasp_pkg::QTR_LAST : s.tick - 8'h01;
        case (s.state)
            HS_IDLE: begin
                next_s.tick = vasp_pkg::QTR_LAST;
                next_s.qtr = 2'h0;
                if (CMD_VALID_I) begin
                    next_s.ready = 1'b0;
                    next_s.bitcnt = 4'h0;
                    case (vasp_pkg::vasp_cmd_t'(CMD_I))
                        vasp_pkg::CMD_START: next_s.state = HS_START;
                        vasp_pkg::CMD_STOP: next_s.state = HS_STOP;
                        vasp_pkg::CMD_WRITE: begin
                            next_s.tx = {CMD_DATA_I, 1'b1};
                            next_s.state = HS_BIT;
                        end
                        vasp_pkg::CMD_READ_ACK: begin
                            next_s.tx = {8'hff, 1'b0};
                            next_s.state = HS_BIT;
                        end
                        vasp_pkg::CMD_READ_NACK: begin
                            next_s.tx = {8'hff, 1'b1};
                            next_s.state = HS_BIT;
                        end
                        default: next_s.ready = 1'b1;
                    endcase
                end
            end
            HS_START: begin
                if (step) begin
                    next_s.qtr = s.qtr + 2'h1;
                    case (s.qtr)
                        2'h0: next_s.sda_oe = 1'b0;
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sda_oe = 1'b1;
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.state = HS_IDLE;
                            next_s.ready = 1'b1;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
            end
            HS_STOP: begin
                if (step) begin
                    next_s.qtr = s.qtr + 2'h1;
                    case (s.qtr)
                        2'h0: next_s.sda_oe = 1'b1;
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sda_oe = 1'b0;
                        default: begin
                            next_s.state = HS_IDLE;
                            next_s.ready = 1'b1;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
            end
            HS_BIT: begin
                if (step) begin
                    next_s.qtr = s.qtr + 2'h1;
                    case (s.qtr)
                        2'h0: begin
                            next_s.sda_oe = !s.tx[8];
                            next_s.tx = {s.tx[7:0], 1'b1};
                        end
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.rx = {s.rx[7:0], s.sda_s};
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.bitcnt = s.bitcnt + 4'h1;
                            if (s.bitcnt == vasp_pkg::BITS_PER_SLOT - 4'h1) begin
                                next_s.sda_oe = 1'b0;
                                next_s.rdata = s.rx[8:1];
                                next_s.ack = !s.rx[0];
                                next_s.state = HS_IDLE;
                                next_s.ready = 1'b1;
                                next_s.done = 1'b1;
                            end
                        end
                    endcase
                end
            end
            default: next_s.state = HS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s <= '{
                sda_m: 1'b1, sda_s: 1'b1, state: HS_IDLE, tick: 8'h00, qtr: 2'h0,
                bitcnt: 4'h0, tx: 9'h1ff, rx: 9'h000, scl_oe: 1'b0, sda_oe: 1'b0,
                ready: 1'b1, done: 1'b0, rdata: vasp_pkg::BYTE_RST, ack: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    assign bus.scl_out_host = 1'b0;
    assign bus.scl_oe_host = s.scl_oe;
    assign bus.sda_out_host = 1'b0;
    assign bus.sda_oe_host = s.sda_oe;
    assign CMD_READY_O = s.ready;
    assign DONE_O = s.done;
    assign RDATA_O = s.rdata;
    assign ACK_O = s.ack;

endmodule

// ### test/vasp_checker.sv
`timescale 1ns/1ps
module vasp_checker (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_out_host,
    input wire logic scl_oe_host,
    input wire logic sda_out_host,
    input wire logic sda_oe_host,
    input wire logic sda_out_dev,
    input wire logic sda_oe_dev
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic scl_q, sda_q, first, rd, acked, seen;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rise, start, stop;
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop = scl && scl_q && !sda_q && sda;
    // Frame decoder seen from the wires
    always_ff @(posedge CLK_I) begin
        scl_q <= scl;
        sda_q <= sda;
        if (!RST_N_I) begin
            bit_cnt <= 4'h0;
            first <= 1'h0;
            acked <= 1'h0;
            seen <= 1'h0;
        end else if (start) begin
            bit_cnt <= 4'h0;
            first <= 1'h1;
            acked <= 1'h0;
            seen <= 1'h1;
        end else if (stop) begin
            first <= 1'h0;
            acked <= 1'h0;
        end else if (rise) begin
            if (bit_cnt == 4'h8) begin
                bit_cnt <= 4'h0;
                first <= 1'h0;
                if (first) begin
                    rd <= shreg[0];
                    acked <= sda_oe_dev;
                end
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shreg <= {shreg[6:0], sda};
            end
        end
    end
    a_open_drain_only: assert property (!sda_out_dev && !sda_out_host && !scl_out_host)
        else $error("high level driven on an open-drain line");
    a_ignore_before_start: assert property (!seen |-> !sda_oe_dev)
        else $error("device drove data before any start");
    a_foreign_no_ack: assert property (rise && bit_cnt == 4'h8 && first && shreg[7:2] != vasp_pkg::ADDR_HI |-> !sda_oe_dev)
        else $error("foreign address acknowledged");
    a_write_byte_ack: assert property (rise && bit_cnt == 4'h8 && !first && acked && !rd |-> sda_oe_dev)
        else $error("written byte not acknowledged");
    a_read_host_ack: assert property (rise && bit_cnt == 4'h8 && !first && acked && rd |-> !sda_oe_dev)
        else $error("device drove the host ack slot");
    a_stable_scl_high: assert property (scl && scl_q |-> $stable(sda_oe_dev))
        else $error("device data moved while clock high");
    a_change_after_fall: assert property ($changed(sda_oe_dev) |-> !scl && !$past(scl, 3))
        else $error("device data moved too soon after clock fall");
    a_stop_release: assert property (stop |=> !sda_oe_dev [*8])
        else $error("device holds data after stop");
    cover property (rise && bit_cnt == 4'h8 && !first && acked && !rd);
    cover property (rise && bit_cnt == 4'h8 && !first && acked && rd);
    cover property (start && acked);
endmodule

// ### test/video_afe_serial_config_port_tb.sv
`timescale 1ns/1ps
module video_afe_serial_config_port_tb;
    logic CLK_I = 1'h0;
    logic RST_N_I = 1'h0;
    logic strap = 1'h0;
    logic cmd_valid = 1'h0;
    logic [2:0] cmd = 3'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, done, ack, reg_wr, reg_rd;
    logic [7:0] rdata, reg_addr, reg_wdata;
    logic [7:0] regs [256];
    int err_total = 0;
    int comparisons = 0;
    int rd_count = 0;

    vasp_if i_vasp_if();
    vasp_host i_vasp_host (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .bus(i_vasp_if), .CMD_VALID_I(cmd_valid),
        .CMD_I(cmd), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready), .DONE_O(done), .RDATA_O(rdata), .ACK_O(ack));
    vasp_dev i_vasp_dev (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .STRAP_I(strap), .bus(i_vasp_if),
        .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
        .REG_RDATA_I(regs[reg_addr]));
    vasp_checker i_vasp_checker (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .scl(i_vasp_if.scl), .sda(i_vasp_if.sda),
        .scl_out_host(i_vasp_if.scl_out_host), .scl_oe_host(i_vasp_if.scl_oe_host),
        .sda_out_host(i_vasp_if.sda_out_host), .sda_oe_host(i_vasp_if.sda_oe_host),
        .sda_out_dev(i_vasp_if.sda_out_dev), .sda_oe_dev(i_vasp_if.sda_oe_dev));

    always #2 CLK_I = ~CLK_I;

    // Register file behind the port
    always @(posedge CLK_I) begin
        if (reg_wr === 1'h1) begin
            regs[reg_addr] <= reg_wdata;
        end
    end

    // Read strobes seen on the register side
    always @(posedge CLK_I) begin
        if (reg_rd === 1'h1) begin
            rd_count <= rd_count + 1;
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_cmd(input vasp_pkg::vasp_cmd_t c, input logic [7:0] d);
        int n;
        @(posedge CLK_I);
        cmd_valid <= 1'h1;
        cmd <= c;
        cmd_data <= d;
        @(posedge CLK_I);
        cmd_valid <= 1'h0;
        @(negedge CLK_I);
        check({7'h00, cmd_ready}, 8'h00);
        n = 0;
        while (done !== 1'h1 && n < 400) begin
            @(negedge CLK_I);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("mismatch at %0t: command never finished", $time);
        end
        check({7'h00, cmd_ready}, 8'h01);
    endtask

    task automatic wr(input logic [7:0] d, input logic a);
        do_cmd(vasp_pkg::CMD_WRITE, d);
        check({7'h00, ack}, {7'h00, a});
    endtask

    task automatic rd(input logic last, input logic [7:0] exp);
        do_cmd(last ? vasp_pkg::CMD_READ_NACK : vasp_pkg::CMD_READ_ACK, 8'h00);
        check(rdata, exp);
    endtask

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 8'h40 + 8'(i);
        repeat (10) @(posedge CLK_I);
        RST_N_I <= 1'h1;
        repeat (10) @(posedge CLK_I);
        wr(8'h98, 1'h0);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h9a, 1'h0);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h30, 1'h0);
        do_cmd(vasp_pkg::CMD_STOP, 8'h00);
        // Sequential read of 28 registers from index zero
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h98, 1'h1);
        wr(8'h00, 1'h1);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h99, 1'h1);
        for (int i = 0; i < 28; i++) rd(i == 27, 8'h40 + 8'(i));
        do_cmd(vasp_pkg::CMD_STOP, 8'h00);
        check(8'(rd_count), 8'h1c);
        check({6'h00, i_vasp_if.scl, i_vasp_if.sda}, 8'h03);
        // Undefined command is ignored and leaves the bus idle
        @(posedge CLK_I);
        cmd_valid <= 1'h1;
        cmd <= 3'h7;
        @(posedge CLK_I);
        cmd_valid <= 1'h0;
        @(negedge CLK_I);
        check({4'h0, cmd_ready, done, i_vasp_if.scl, i_vasp_if.sda}, 8'h0b);
        // Burst write, then read back across a repeated start
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h98, 1'h1);
        wr(8'h10, 1'h1);
        wr(8'ha1, 1'h1);
        wr(8'ha2, 1'h1);
        wr(8'ha3, 1'h1);
        do_cmd(vasp_pkg::CMD_STOP, 8'h00);
        check(regs[8'h10], 8'ha1);
        check(regs[8'h11], 8'ha2);
        check(regs[8'h12], 8'ha3);
        check(regs[8'h13], 8'h53);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h98, 1'h1);
        wr(8'h11, 1'h1);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h99, 1'h1);
        rd(1'h0, 8'ha2);
        rd(1'h1, 8'ha3);
        do_cmd(vasp_pkg::CMD_STOP, 8'h00);
        check(8'(rd_count), 8'h1e);
        // Strap high moves the port to the odd address
        @(posedge CLK_I);
        strap <= 1'h1;
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h98, 1'h0);
        do_cmd(vasp_pkg::CMD_START, 8'h00);
        wr(8'h9a, 1'h1);
        wr(8'h20, 1'h1);
        wr(8'h5e, 1'h1);
        do_cmd(vasp_pkg::CMD_STOP, 8'h00);
        check(regs[8'h20], 8'h5e);
        check(regs[8'h21], 8'h61);
        final_report();
    end
endmodule
